/* hw/rai_ctrl.sv */
// Reset, RAM self-test, EEPROM auto-initialization, EEPROM copy and interrupt style.
`timescale 1ns/1ps
module rai_ctrl
  import rai_pkg::*;
#(
  parameter int EE_WRITE_CYCLES = EE_WRITE_CYC,
  parameter int EE_PAGE_WORDS = EE_PAGE_WORDS_DEF
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic master_rst_n,
  input wire logic soft_reset_bit,
  input wire logic start_exec_bit,
  input wire logic irq_style_sel,
  input wire logic ram_test_disable,
  input wire logic eeprom_copy_req,
  input wire logic autoinit_enable,
  input wire logic short_range_sel,
  input wire logic hw_irq_evt,
  input wire logic msg_irq_evt,
  input wire logic hw_irq_clr,
  input wire logic msg_irq_clr,
  output logic hw_irq_n,
  output logic msg_irq_n,
  output logic ready,
  output logic term_run,
  output logic core_rst_n,
  output logic ram_test_fail,
  output logic ram_req,
  output logic ram_we,
  output logic [ADDR_W-1:0] ram_addr,
  output logic [DATA_W-1:0] ram_wdata,
  input wire logic ram_ready,
  input wire logic [DATA_W-1:0] ram_rdata,
  output logic eeprom_chip_sel_n,
  output logic eeprom_sclk,
  output logic eeprom_mosi,
  input wire logic eeprom_miso
);
  localparam int WW = $clog2(EE_WRITE_CYCLES + 1);
  localparam int PGW = $clog2(EE_PAGE_WORDS);
  localparam int BPW = $clog2(BUF_DEPTH);
  localparam int BCW = $clog2(BUF_DEPTH + 1);
  localparam int IPW = $clog2(IRQ_PULSE_CYC + 1);

  rai_spi_if spi_bus ();

  logic [SY_N-1:0] pins_raw, sync1_q, sync2_q;
  logic hold, hold_q, start_seq, copy_q, copy_rise;
  rai_state_e state_q;
  logic [ADDR_W-1:0] addr_q, last_q, wr_addr_q, rd_addr_q;
  logic [1:0] pass_q, bcnt_q;
  logic hi_q, autoinit_enable_q, fin_q, xfer_q, word_ok_q, cp_pend_q, rd_pend_q, rd_inv_q;
  logic [7:0] hibyte_q;
  logic [DATA_W-1:0] cp_word_q;
  logic [PGW-1:0] pg_q;
  logic [WW-1:0] wait_q;
  logic want;
  logic [7:0] tx;
  logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
  logic [BPW-1:0] buf_wp_q, buf_rp_q;
  logic [BCW-1:0] buf_cnt_q;
  logic buf_in_ready, buf_out_valid, buf_push, buf_pop;

  function automatic logic [DATA_W-1:0] pattern(input logic [ADDR_W-1:0] a, input logic inv);
    logic [DATA_W-1:0] p;
    p = {1'b0, a} ^ TEST_PAT;
    return inv ? ~p : p;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronizers
  // ----------------------------------------------------------------------
  assign pins_raw = {eeprom_miso, short_range_sel, autoinit_enable, eeprom_copy_req,
                     ram_test_disable, master_rst_n};

  for (genvar i = 0; i < SY_N; i++) begin : g_sync
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= pins_raw[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Reset sources and edges
  // ----------------------------------------------------------------------
  assign hold = ~sync2_q[SY_RST] | soft_reset_bit;
  assign start_seq = hold_q & ~hold;
  assign copy_rise = sync2_q[SY_COPY] & ~copy_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_q <= 1'b1;
      copy_q <= 1'b0;
      core_rst_n <= 1'b0;
      ready <= 1'b0;
      term_run <= 1'b0;
    end else begin
      hold_q <= hold;
      copy_q <= sync2_q[SY_COPY];
      core_rst_n <= ~hold;
      ready <= ~hold && (state_q == S_READY);
      term_run <= ~hold && (state_q == S_READY) && start_exec_bit;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= S_HOLD;
      addr_q <= '0;
      last_q <= FULL_LAST;
      pass_q <= 2'h0;
      bcnt_q <= 2'h0;
      hi_q <= 1'b1;
      hibyte_q <= 8'h00;
      autoinit_enable_q <= 1'b0;
      fin_q <= 1'b0;
      xfer_q <= 1'b0;
      word_ok_q <= 1'b0;
      cp_pend_q <= 1'b0;
      cp_word_q <= '0;
      pg_q <= '0;
      wait_q <= '0;
    end else if (hold) begin
      state_q <= S_HOLD;
      xfer_q <= 1'b0;
      word_ok_q <= 1'b0;
      cp_pend_q <= 1'b0;
    end else begin
      if (spi_bus.start) begin
        xfer_q <= 1'b1;
      end else if (spi_bus.done) begin
        xfer_q <= 1'b0;
      end
      case (state_q)
        S_HOLD: begin
          if (start_seq) begin
            addr_q <= '0;
            pass_q <= 2'h0;
            bcnt_q <= 2'h0;
            autoinit_enable_q <= sync2_q[SY_AUTO];
            last_q <= sync2_q[SY_SHORT] ? SHORT_LAST : FULL_LAST;
            if (!sync2_q[SY_MTOFF]) begin
              state_q <= S_TEST;
            end else begin
              state_q <= sync2_q[SY_AUTO] ? S_LD_CMD : S_READY;
            end
          end
        end
        S_TEST: begin
          if (ram_ready) begin
            if (addr_q == FULL_LAST) begin
              addr_q <= '0;
              pass_q <= pass_q + 2'h1;
              if (pass_q == 2'h3) begin
                state_q <= autoinit_enable_q ? S_LD_CMD : S_READY;
              end
            end else begin
              addr_q <= addr_q + 15'h1;
            end
          end
        end
        S_LD_CMD, S_CP_CMD: begin
          if (spi_bus.done) begin
            if (bcnt_q == 2'h2) begin
              state_q <= (state_q == S_LD_CMD) ? S_LD_DATA : S_CP_DATA;
              hi_q <= 1'b1;
            end else begin
              bcnt_q <= bcnt_q + 2'h1;
            end
          end
        end
        S_LD_DATA: begin
          if (spi_bus.done) begin
            hi_q <= ~hi_q;
            if (hi_q) begin
              hibyte_q <= spi_bus.rx_byte;
            end else if (addr_q == last_q) begin
              state_q <= S_LD_DRAIN;
            end else begin
              addr_q <= addr_q + 15'h1;
            end
          end
        end
        S_LD_DRAIN: begin
          if (!buf_out_valid) begin
            state_q <= S_READY;
          end
        end
        S_READY: begin
          if (copy_rise) begin
            state_q <= S_CP_WREN;
            addr_q <= '0;
            bcnt_q <= 2'h0;
            pg_q <= '0;
            fin_q <= 1'b0;
            wait_q <= '0;
          end
        end
        S_CP_WREN: begin
          if (bcnt_q == 2'h0) begin
            if (spi_bus.done) begin
              bcnt_q <= 2'h1;
              wait_q <= '0;
            end
          end else if (wait_q == WW'(SCLK_HALF_CYC)) begin
            state_q <= S_CP_CMD;
            bcnt_q <= 2'h0;
          end else begin
            wait_q <= wait_q + WW'(1);
          end
        end
        S_CP_DATA: begin
          cp_pend_q <= ram_req & ram_ready;
          if (cp_pend_q) begin
            cp_word_q <= ram_rdata;
            word_ok_q <= 1'b1;
          end
          if (spi_bus.done) begin
            hi_q <= ~hi_q;
            if (!hi_q) begin
              word_ok_q <= 1'b0;
              wait_q <= '0;
              if (addr_q == FULL_LAST) begin
                fin_q <= 1'b1;
                state_q <= S_CP_WAIT;
              end else begin
                addr_q <= addr_q + 15'h1;
                pg_q <= pg_q + PGW'(1);
                if (pg_q == PGW'(EE_PAGE_WORDS - 1)) begin
                  state_q <= S_CP_WAIT;
                end
              end
            end
          end
        end
        S_CP_WAIT: begin
          // The EEPROM is busy with its internal write.
          if (wait_q == WW'(EE_WRITE_CYCLES - 1)) begin
            state_q <= fin_q ? S_READY : S_CP_WREN;
            bcnt_q <= 2'h0;
            wait_q <= '0;
          end else begin
            wait_q <= wait_q + WW'(1);
          end
        end
        default: begin
          state_q <= S_HOLD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // RAM self-test checker
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= '0;
      rd_inv_q <= 1'b0;
      ram_test_fail <= 1'b0;
    end else begin
      rd_pend_q <= ~hold && (state_q == S_TEST) && pass_q[0] && ram_ready;
      rd_addr_q <= addr_q;
      rd_inv_q <= pass_q[1];
      if (start_seq) begin
        ram_test_fail <= 1'b0;
      end else if (rd_pend_q && (ram_rdata != pattern(rd_addr_q, rd_inv_q))) begin
        ram_test_fail <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // SPI byte requests
  // ----------------------------------------------------------------------
  always_comb begin
    want = 1'b0;
    tx = 8'h00;
    case (state_q)
      S_LD_CMD, S_CP_CMD: begin
        want = 1'b1;
        case (bcnt_q)
          2'h0: tx = (state_q == S_LD_CMD) ? CMD_READ : CMD_WRITE;
          2'h1: tx = addr_q[14:7];
          default: tx = {addr_q[6:0], 1'b0};
        endcase
      end
      S_LD_DATA: want = buf_in_ready;
      S_CP_WREN: begin
        want = (bcnt_q == 2'h0);
        tx = CMD_WREN;
      end
      S_CP_DATA: begin
        want = word_ok_q;
        tx = hi_q ? cp_word_q[15:8] : cp_word_q[7:0];
      end
      default: want = 1'b0;
    endcase
  end

  assign spi_bus.start = want & ~xfer_q & ~spi_bus.busy & ~hold;
  assign spi_bus.tx_byte = tx;
  assign spi_bus.cs_on = ~hold && ((state_q == S_LD_CMD) || (state_q == S_LD_DATA) ||
                         (state_q == S_CP_CMD) || (state_q == S_CP_DATA) ||
                         ((state_q == S_CP_WREN) && (bcnt_q == 2'h0)));

  rai_spi_master u_spi (
    .clk(clk),
    .reset_n(reset_n),
    .spi(spi_bus),
    .miso_s(sync2_q[SY_MISO]),
    .eeprom_sclk(eeprom_sclk),
    .eeprom_mosi(eeprom_mosi),
    .eeprom_chip_sel_n(eeprom_chip_sel_n)
  );

  // ----------------------------------------------------------------------
  // Load buffer: a stalled RAM port stops the SPI reads instead of losing words
  // ----------------------------------------------------------------------
  assign buf_in_ready = (buf_cnt_q != BCW'(BUF_DEPTH));
  assign buf_out_valid = (buf_cnt_q != '0);
  assign buf_push = (state_q == S_LD_DATA) && spi_bus.done && !hi_q && !hold;
  assign buf_pop = buf_out_valid && ram_ready && !hold &&
                   ((state_q == S_LD_DATA) || (state_q == S_LD_DRAIN));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_wp_q <= '0;
      buf_rp_q <= '0;
      buf_cnt_q <= '0;
      wr_addr_q <= '0;
    end else if (hold) begin
      buf_wp_q <= '0;
      buf_rp_q <= '0;
      buf_cnt_q <= '0;
      wr_addr_q <= '0;
    end else begin
      if (buf_push) begin
        buf_mem[buf_wp_q] <= {hibyte_q, spi_bus.rx_byte};
        buf_wp_q <= buf_wp_q + BPW'(1);
      end
      if (buf_pop) begin
        buf_rp_q <= buf_rp_q + BPW'(1);
        wr_addr_q <= wr_addr_q + 15'h1;
      end
      buf_cnt_q <= buf_cnt_q + BCW'(buf_push) - BCW'(buf_pop);
    end
  end

  // ----------------------------------------------------------------------
  // RAM port
  // ----------------------------------------------------------------------
  always_comb begin
    ram_req = 1'b0;
    ram_we = 1'b0;
    ram_addr = addr_q;
    ram_wdata = '0;
    if (!hold) begin
      case (state_q)
        S_TEST: begin
          ram_req = 1'b1;
          ram_we = ~pass_q[0];
          ram_wdata = pattern(addr_q, pass_q[1]);
        end
        S_LD_DATA, S_LD_DRAIN: begin
          ram_req = buf_out_valid;
          ram_we = 1'b1;
          ram_addr = wr_addr_q;
          ram_wdata = buf_mem[buf_rp_q];
        end
        S_CP_DATA: ram_req = ~word_ok_q & ~cp_pend_q;
        default: ram_req = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt outputs: style select high holds the level until cleared
  // ----------------------------------------------------------------------
  logic [1:0] irq_evt, irq_clr, irq_n_q;
  assign irq_evt = {msg_irq_evt, hw_irq_evt};
  assign irq_clr = {msg_irq_clr, hw_irq_clr};

  for (genvar c = 0; c < 2; c++) begin : g_irq
    logic lvl_q;
    logic [IPW-1:0] pcnt_q;
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        lvl_q <= 1'b0;
        pcnt_q <= '0;
        irq_n_q[c] <= 1'b1;
      end else if (hold) begin
        lvl_q <= 1'b0;
        pcnt_q <= '0;
        irq_n_q[c] <= 1'b1;
      end else begin
        if (irq_evt[c]) begin
          lvl_q <= 1'b1;
          pcnt_q <= IPW'(IRQ_PULSE_CYC);
        end else begin
          if (irq_clr[c]) begin
            lvl_q <= 1'b0;
          end
          if (pcnt_q != '0) begin
            pcnt_q <= pcnt_q - IPW'(1);
          end
        end
        irq_n_q[c] <= irq_style_sel ? ~(irq_evt[c] | (lvl_q & ~irq_clr[c])) :
                      ~(irq_evt[c] | (pcnt_q > IPW'(1)));
      end
    end
  end

  assign hw_irq_n = irq_n_q[0];
  assign msg_irq_n = irq_n_q[1];
endmodule

/* hw/rai_pkg.sv */
// Constants and types for the reset and auto-initialization controller.
// How it works
// - The hardware interrupt output is active low, shown as a short pulse or held level per the style select bit.
// - The message interrupt output is active low and follows the same pulse or level style select bit.
// - Master reset is active low; reset holds while it is low and the sequence starts on its rising edge.
// - Setting the software-reset bit resets the block just as master reset does.
// - With the RAM test disable input low, the whole internal RAM is tested after reset release.
// - With the RAM test disable input high, the RAM test is skipped to shorten reset.
// - A rising edge on the EEPROM copy input while ready starts writing registers and tables out to the EEPROM.
// - Auto-init enable is sampled at reset release and, when high, RAM is loaded from the EEPROM over SPI.
// - With short-range select low, auto-init covers addresses 0x0 through 0x7FFF.
// - With short-range select high, auto-init covers only addresses 0x0 through 0x03FF.
// - Short-range select is ignored whenever auto-init enable is low.
// - Data read from the EEPROM fully configures the tables.
// - Ready stays low during test or auto-init, and the host must wait for ready before any access.
// - Terminal operation runs only while ready is high and the start-execution bit is set.
// - The block is master of the EEPROM SPI and drives its chip select and serial clock.
package rai_pkg;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCLK_PERIOD_NS = 125;
  localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int IRQ_PULSE_NS = 80;
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EE_WRITE_MS = 5;
  localparam int EE_WRITE_CYC = EE_WRITE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int EE_PAGE_WORDS_DEF = 32;
  localparam int BUF_DEPTH = 2;
  // ----------------------------------------------------------------------
  // Address ranges, data and EEPROM commands
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] FULL_LAST = 15'h7FFF;
  localparam logic [ADDR_W-1:0] SHORT_LAST = 15'h03FF;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [DATA_W-1:0] TEST_PAT = 16'h5555;
  // ----------------------------------------------------------------------
  // Synchronized pin positions
  // ----------------------------------------------------------------------
  localparam int SY_RST = 0;
  localparam int SY_MTOFF = 1;
  localparam int SY_COPY = 2;
  localparam int SY_AUTO = 3;
  localparam int SY_SHORT = 4;
  localparam int SY_MISO = 5;
  localparam int SY_N = 6;
  // ----------------------------------------------------------------------
  // Sequencer states, Gray coded along the reset path
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_HOLD = 4'h0,
    S_TEST = 4'h1,
    S_LD_CMD = 4'h3,
    S_LD_DATA = 4'h2,
    S_LD_DRAIN = 4'h6,
    S_READY = 4'h7,
    S_CP_WREN = 4'h5,
    S_CP_CMD = 4'h4,
    S_CP_DATA = 4'hC,
    S_CP_WAIT = 4'hD
  } rai_state_e;
endpackage

/* hw/rai_spi_if.sv */
// Byte-transfer handshake between the sequencer and the SPI engine.
`timescale 1ns/1ps
interface rai_spi_if;
  logic start;
  logic [7:0] tx_byte;
  logic cs_on;
  logic busy;
  logic done;
  logic [7:0] rx_byte;
  modport ctl (output start, output tx_byte, output cs_on, input busy, input done, input rx_byte);
  modport eng (input start, input tx_byte, input cs_on, output busy, output done, output rx_byte);
endinterface

/* hw/rai_spi_master.sv */
// Mode 0 SPI master engine that moves one byte per start request.
`timescale 1ns/1ps
module rai_spi_master
  import rai_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  rai_spi_if.eng spi,
  input wire logic miso_s,
  output logic eeprom_sclk,
  output logic eeprom_mosi,
  output logic eeprom_chip_sel_n
);
  localparam int DW = $clog2(SCLK_HALF_CYC + 1);

  logic [DW-1:0] div_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  logic tick;

  // ----------------------------------------------------------------------
  // Half-period enable, only running inside a byte
  // ----------------------------------------------------------------------
  assign tick = spi.busy && (div_q == DW'(SCLK_HALF_CYC - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= '0;
    end else if (!spi.busy || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DW'(1);
    end
  end

  // ----------------------------------------------------------------------
  // Shifter: data leaves on the falling edge and is caught on the rising
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      spi.busy <= 1'b0;
      spi.done <= 1'b0;
      spi.rx_byte <= 8'h00;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      eeprom_sclk <= 1'b0;
      eeprom_mosi <= 1'b0;
    end else begin
      spi.done <= 1'b0;
      if (!spi.busy) begin
        if (spi.start) begin
          spi.busy <= 1'b1;
          bit_q <= 3'h0;
          sh_q <= spi.tx_byte;
          eeprom_mosi <= spi.tx_byte[7];
        end
      end else if (tick) begin
        if (!eeprom_sclk) begin
          eeprom_sclk <= 1'b1;
          rx_q <= {rx_q[6:0], miso_s};
        end else begin
          eeprom_sclk <= 1'b0;
          if (bit_q == 3'h7) begin
            spi.busy <= 1'b0;
            spi.done <= 1'b1;
            spi.rx_byte <= rx_q;
          end else begin
            bit_q <= bit_q + 3'h1;
            sh_q <= {sh_q[6:0], 1'b0};
            eeprom_mosi <= sh_q[6];
          end
        end
      end
      if (!spi.cs_on) {spi.busy, eeprom_sclk} <= 2'b00;
    end
  end

  // Select is registered so it never glitches between frames.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eeprom_chip_sel_n <= 1'b1;
    end else begin
      eeprom_chip_sel_n <= ~spi.cs_on;
    end
  end
endmodule

/* test/rai_ee_model.sv */
// Behavioural serial EEPROM that answers on the load port.
`timescale 1ns/1ps
module rai_ee_model (
  input wire logic eeprom_chip_sel_n,
  input wire logic eeprom_sclk,
  input wire logic eeprom_mosi,
  output logic eeprom_miso,
  output logic [23:0] hdr,
  output int nbits
);
  int j;
  logic [7:0] v;
  initial begin
    eeprom_miso = 1'b0;
    hdr = 24'h000000;
    nbits = 0;
  end
  always @(negedge eeprom_chip_sel_n) begin
    nbits = 0;
    hdr = 24'h000000;
  end
  always @(posedge eeprom_sclk) begin
    if (!eeprom_chip_sel_n) begin
      if (nbits < 24) hdr = {hdr[22:0], eeprom_mosi};
      nbits = nbits + 1;
    end
  end
  // Data byte j after the head is A0h xor j, MSB first, changed on the falling clock.
  always @(negedge eeprom_sclk) begin
    j = (nbits - 24) / 8;
    v = 8'hA0 ^ j[7:0];
    if (!eeprom_chip_sel_n && nbits >= 24) eeprom_miso = v[7 - nbits % 8];
  end
  // No pull resistor, so a released line shows the inverse.
  always @(posedge eeprom_chip_sel_n) eeprom_miso = ~eeprom_miso;
endmodule

/* test/rai_ctrl_properties.sv */
// Port checks for the reset and auto-initialization controller.
`timescale 1ns/1ps
module rai_ctrl_chk
  import rai_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic master_rst_n,
  input wire logic soft_reset_bit,
  input wire logic start_exec_bit,
  input wire logic irq_style_sel,
  input wire logic hw_irq_evt,
  input wire logic msg_irq_evt,
  input wire logic msg_irq_clr,
  input wire logic hw_irq_n,
  input wire logic msg_irq_n,
  input wire logic ready,
  input wire logic term_run,
  input wire logic ram_req,
  input wire logic ram_ready,
  input wire logic [ADDR_W-1:0] ram_addr,
  input wire logic eeprom_chip_sel_n,
  input wire logic eeprom_sclk
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------------
  // Length of the current low phase of the hardware interrupt
  // ----------------------------------------------------------------------
  logic [7:0] low_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_q <= 8'h00;
    end else begin
      low_q <= hw_irq_n ? 8'h00 : low_q + 8'h01;
    end
  end
  hw_evt_a: assert property (hw_irq_evt && ready |=> !hw_irq_n)
    else $error("hardware interrupt missed an event");
  pulse_len_a: assert property ($rose(hw_irq_n) && !irq_style_sel |-> low_q == 8'(IRQ_PULSE_CYC))
    else $error("hardware interrupt pulse has the wrong length");
  msg_evt_a: assert property (msg_irq_evt && ready |=> !msg_irq_n)
    else $error("message interrupt missed an event");
  level_hold_a: assert property (irq_style_sel && ready && !msg_irq_n && !msg_irq_clr |=> !msg_irq_n)
    else $error("level interrupt released without a clear");
  level_clr_a: assert property (irq_style_sel && msg_irq_clr && !msg_irq_evt |=> msg_irq_n)
    else $error("level interrupt not released by a clear");
  mr_hold_a: assert property (!master_rst_n [*5] |-> !ready && !term_run)
    else $error("ready while master reset is held");
  soft_hold_a: assert property (soft_reset_bit [*3] |-> !ready)
    else $error("ready while software reset is held");
  run_start_a: assert property (term_run |-> $past(start_exec_bit))
    else $error("terminal runs without the start bit");
  sclk_idle_a: assert property (eeprom_chip_sel_n |-> !eeprom_sclk)
    else $error("serial clock moves while deselected");
  ram_hold_a: assert property (ram_req && !ram_ready && master_rst_n && !soft_reset_bit |=>
    ram_req && $stable(ram_addr))
    else $error("stalled memory request changed");
endmodule
bind rai_ctrl rai_ctrl_chk i_rai_ctrl_chk (.clk, .reset_n, .master_rst_n, .soft_reset_bit,
  .start_exec_bit, .irq_style_sel, .hw_irq_evt, .msg_irq_evt, .msg_irq_clr, .hw_irq_n,
  .msg_irq_n, .ready, .term_run, .ram_req, .ram_ready, .ram_addr, .eeprom_chip_sel_n,
  .eeprom_sclk);

/* test/testbench.sv */
// Self-checking bench for the reset and auto-initialization controller.
`timescale 1ns/1ps
module testbench
  import rai_pkg::*;
;
  logic clk, reset_n, master_rst_n, soft_reset_bit, start_exec_bit, irq_style_sel;
  logic ram_test_disable, eeprom_copy_req, autoinit_enable, short_range_sel;
  logic hw_irq_evt, msg_irq_evt, hw_irq_clr, msg_irq_clr, hw_irq_n, msg_irq_n;
  logic ready, term_run, core_rst_n, ram_test_fail, ram_req, ram_we, ram_ready;
  logic [ADDR_W-1:0] ram_addr;
  logic [DATA_W-1:0] ram_wdata, ram_rdata;
  logic eeprom_chip_sel_n, eeprom_sclk, eeprom_mosi, eeprom_miso;
  logic [23:0] hdr;
  int nbits, fails, cmp_count, cyc, n, k;
  // The short write wait keeps page gaps in the copy brief.
  rai_ctrl #(.EE_WRITE_CYCLES(200)) i_rai_ctrl (
    .clk, .reset_n, .master_rst_n, .soft_reset_bit, .start_exec_bit, .irq_style_sel,
    .ram_test_disable, .eeprom_copy_req, .autoinit_enable, .short_range_sel, .hw_irq_evt,
    .msg_irq_evt, .hw_irq_clr, .msg_irq_clr, .hw_irq_n, .msg_irq_n, .ready, .term_run,
    .core_rst_n, .ram_test_fail, .ram_req, .ram_we, .ram_addr, .ram_wdata, .ram_ready,
    .ram_rdata, .eeprom_chip_sel_n, .eeprom_sclk, .eeprom_mosi, .eeprom_miso);
  rai_ee_model i_rai_ee_model (.eeprom_chip_sel_n, .eeprom_sclk, .eeprom_mosi, .eeprom_miso,
    .hdr, .nbits);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cycles(input int c);
    repeat (c) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("wrong value at %0t ns: timeout", $time);
      finish_test();
    end
  end
  // ----------------------------------------------------------------------
  // Stimulus, applied on the falling clock
  // ----------------------------------------------------------------------
  initial begin
    {reset_n, master_rst_n, soft_reset_bit, start_exec_bit, irq_style_sel} = 5'b00000;
    {ram_test_disable, eeprom_copy_req, autoinit_enable, short_range_sel} = 4'b1001;
    {hw_irq_evt, msg_irq_evt, hw_irq_clr, msg_irq_clr, ram_ready} = 5'b00001;
    ram_rdata = 16'h0000;
    cycles(20);
    reset_n = 1'b1;
    chk({ready, hw_irq_n, msg_irq_n, eeprom_chip_sel_n}, 4'h7);
    cycles(10);
    master_rst_n = 1'b1;
    for (n = 0; n < 60 && ready !== 1'b1; n++) @(negedge clk);
    chk({ready, eeprom_chip_sel_n, term_run, core_rst_n}, 4'hD);
    start_exec_bit = 1'b1;
    cycles(3);
    chk(term_run, 1'b1);
    for (k = 0; k < 2; k++) begin
      irq_style_sel = k[0];
      {hw_irq_evt, msg_irq_evt} = 2'b11;
      cycles(1);
      {hw_irq_evt, msg_irq_evt} = 2'b00;
      chk({hw_irq_n, msg_irq_n}, 2'b00);
      cycles(25);
      chk({hw_irq_n, msg_irq_n}, k[0] ? 2'b00 : 2'b11);
      {hw_irq_clr, msg_irq_clr} = 2'b11;
      cycles(1);
      {hw_irq_clr, msg_irq_clr} = 2'b00;
      cycles(1);
      chk({hw_irq_n, msg_irq_n}, 2'b11);
    end
    soft_reset_bit = 1'b1;
    cycles(6);
    chk({ready, term_run, core_rst_n, ram_test_fail}, 4'h0);
    soft_reset_bit = 1'b0;
    for (n = 0; n < 60 && ready !== 1'b1; n++) @(negedge clk);
    chk(ready, 1'b1);
    eeprom_copy_req = 1'b1;
    cycles(6);
    chk(ready, 1'b0);
    eeprom_copy_req = 1'b0;
    for (n = 0; n < 200 && eeprom_chip_sel_n !== 1'b0; n++) @(negedge clk);
    for (n = 0; n < 400 && eeprom_chip_sel_n !== 1'b1; n++) @(negedge clk);
    chk({nbits[7:0], hdr[7:0]}, 16'h0806);
    for (n = 0; n < 200 && eeprom_chip_sel_n !== 1'b0; n++) @(negedge clk);
    for (n = 0; n < 1000 && nbits < 24; n++) @(negedge clk);
    chk(hdr, 24'h020000);
    master_rst_n = 1'b0;
    ram_test_disable = 1'b0;
    short_range_sel = 1'b0;
    cycles(10);
    master_rst_n = 1'b1;
    for (n = 0; n < 60 && ram_req !== 1'b1; n++) @(negedge clk);
    chk({ready, ram_we, ram_addr, ram_wdata}, {2'b01, 15'h0000, TEST_PAT});
    cycles(1);
    chk({ram_we, ram_addr, ram_wdata}, {1'b1, 15'h0001, TEST_PAT ^ 16'h0001});
    master_rst_n = 1'b0;
    {ram_test_disable, autoinit_enable, short_range_sel, ram_ready} = 4'b1110;
    cycles(10);
    master_rst_n = 1'b1;
    for (n = 0; n < 1000 && (nbits < 24 || eeprom_chip_sel_n); n++) @(negedge clk);
    chk(hdr, 24'h030000);
    cycles(3000);
    chk(ready, 1'b0);
    ram_ready = 1'b1;
    for (k = 0; k < 4; k++) begin
      for (n = 0; n < 1200 && ram_req !== 1'b1; n++) @(negedge clk);
      chk({ram_we, ram_addr, 8'hA0 ^ 8'(2 * k), 8'hA0 ^ 8'(2 * k + 1)},
        {1'b1, k[14:0], ram_wdata});
      cycles(1);
    end
    finish_test();
  end
endmodule
